// >>> verilog/rtosp_pkg.sv
// Shared constants for the receive overhead serial port
package rtosp_pkg;

  // Channel and row geometry
  localparam int CHANNELS   = 8;
  localparam int ROW_BYTES  = 36;
  localparam int BYTE_W     = 8;
  localparam int ROW_BITS   = ROW_BYTES * BYTE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 1 + CHANNELS * ROW_BITS;
  localparam int CAP_CNT_W  = 6;
  localparam int BIT_CNT_W  = 9;
  localparam int ROW_W      = 4;
  localparam int COL_W      = 6;

  // Counter end values
  localparam logic [CAP_CNT_W-1:0] LAST_BYTE = CAP_CNT_W'(ROW_BYTES - 1);
  localparam logic [BIT_CNT_W-1:0] LAST_BIT  = BIT_CNT_W'(ROW_BITS - 1);

  // Overhead positions on the parallel bus (row 0..8, column 0..35)
  localparam logic [ROW_W-1:0] FRAMING_ROW  = 4'h0;
  localparam logic [ROW_W-1:0] PTR_ROW      = 4'h3;
  localparam logic [ROW_W-1:0] APS_ROW      = 4'h4;
  localparam logic [COL_W-1:0] A1_LAST_COL  = 6'h0B;
  localparam logic [COL_W-1:0] A2_LAST_COL  = 6'h17;
  localparam logic [COL_W-1:0] K1_COL       = 6'h0C;
  localparam logic [COL_W-1:0] K2_COL       = 6'h18;

  // Byte values
  localparam logic [7:0] A1_VAL    = 8'hF6;
  localparam logic [7:0] A2_VAL    = 8'h28;
  localparam logic [7:0] ONES_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Size bits inside the first pointer byte
  localparam int SS_HI = 3;
  localparam int SS_LO = 2;

  // Overhead serial clock range, sampled by the 200 MHz system clock
  localparam int CLK_KHZ       = 200000;
  localparam int OHCLK_MIN_KHZ = 25000;
  localparam int OHCLK_MAX_KHZ = 77760;

endpackage

// >>> verilog/rtosp_fifo.sv
// Row buffer FIFO with registered read data
`timescale 1ns/100ps
module rtosp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] cnt;
    logic          out_v;
  } rtosp_fifo_state_t;

  rtosp_fifo_state_t q;
  rtosp_fifo_state_t d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic [WIDTH-1:0]  out_data_q;
  logic              push;
  logic              load;

  // Handshake and prefetch into the output register
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign push      = in_valid & in_ready;
  assign load      = (q.cnt != '0) & (~q.out_v | out_ready);
  assign out_valid = q.out_v;
  assign out_data  = out_data_q;

  // Pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
    end
    if (load) begin
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
      d.out_v  = 1'b1;
    end else if (q.out_v & out_ready) begin
      d.out_v = 1'b0;
    end
    d.cnt = q.cnt + CW'(push) - CW'(load);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage and read data register
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wr_ptr] <= in_data;
    end
    if (load) begin
      out_data_q <= mem[q.rd_ptr];
    end
  end

endmodule

// >>> verilog/rtosp_core.sv
// Receive overhead capture, serial port and parallel overhead rebuild
`timescale 1ns/100ps
// Notes on behaviour
// - Each channel captures one 36-byte overhead row in a shift register on clk.
// - A captured row moves to the serial side at payload envelope start.
// - Every overhead byte of a channel leaves on that channel's serial output.
// - Serial data goes in bursts qualified by one clock enable shared by all channels.
// - Overhead bytes leave in the order they appear in the frame.
// - A one-clock row pulse marks the first of the 36 bytes of each row.
// - Row pulse, clock enable and data change on the overhead clock rising edge.
// - Bytes leave unchanged, most significant bit first, except the parity bit.
// - Top bit of first framing byte carries even parity of the previous frame.
// - While line alarm is active all serial bits, parity included, are one.
// - With the pointer mover in use, framing bytes are rebuilt, unused bytes zero.
// - Pointer bytes are rebuilt, size bits transparent, path alarm gives all ones.
// - Pointer action bytes carry elastic store data on negative stuff, else zero.
// - In transport mode with the pointer mover in use, line alarm forces the parallel overhead to all ones.
// - Protection bytes pass through or are zero, as software selects.
// - Output is row by row, framed by row pulse and clock enable.
// - Line alarm is forced by software or raised on out-of-frame when enabled.
module rtosp_core (
  input  wire logic                                                     clk,
  input  wire logic                                                     rst_b,
  input  wire logic                                                     overhead_serial_clock,
  input  wire logic                                                     toh_byte_valid,
  input  wire logic                                                     toh_first_of_frame,
  input  wire logic [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    toh_byte,
  output logic                                                          toh_in_ready,
  input  wire logic                                                     spe_start,
  input  wire logic [rtosp_pkg::CHANNELS-1:0]                           ais_force,
  input  wire logic [rtosp_pkg::CHANNELS-1:0]                           ais_on_oof_en,
  input  wire logic [rtosp_pkg::CHANNELS-1:0]                           oof,
  output logic                                                          rx_overhead_row_pulse,
  output logic                                                          rx_overhead_clock_enable,
  output logic      [rtosp_pkg::CHANNELS-1:0]                           rx_overhead_serial_data,
  input  wire logic                                                     par_in_valid,
  input  wire logic [rtosp_pkg::ROW_W-1:0]                              par_row_idx,
  input  wire logic [rtosp_pkg::COL_W-1:0]                              par_col_idx,
  input  wire logic [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    par_in_data,
  input  wire logic                                                     pm_bypass,
  input  wire logic                                                     transport_mode,
  input  wire logic                                                     aps_pass,
  input  wire logic [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    ptr_h1,
  input  wire logic [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    ptr_h2,
  input  wire logic [rtosp_pkg::CHANNELS-1:0]                           ptr_ais_p,
  input  wire logic [rtosp_pkg::CHANNELS-1:0]                           neg_stuff,
  input  wire logic [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    es_byte,
  output logic                                                          par_out_valid,
  output logic      [rtosp_pkg::CHANNELS-1:0][rtosp_pkg::BYTE_W-1:0]    par_out_data
);

  import rtosp_pkg::*;

  localparam int TOP = ROW_BITS - 1;

  typedef struct packed {
    logic                                 ck_s1;
    logic                                 ck_s2;
    logic                                 ck_prev;
    logic [CHANNELS-1:0][ROW_BITS-1:0]    cap;
    logic [CAP_CNT_W-1:0]                 cap_cnt;
    logic                                 cap_frame;
    logic                                 row_full;
    logic [CHANNELS-1:0][ROW_BITS-1:0]    ser;
    logic [BIT_CNT_W-1:0]                 bit_cnt;
    logic                                 busy;
    logic [CHANNELS-1:0]                  par_acc;
    logic                                 row_pulse;
    logic                                 clk_en;
    logic [CHANNELS-1:0]                  sdata;
    logic                                 par_v;
    logic [CHANNELS-1:0][BYTE_W-1:0]      pbus;
  } rtosp_state_t;

  rtosp_state_t                      q;
  rtosp_state_t                      d;
  logic                              oh_edge;
  logic [CHANNELS-1:0]               ais_l;
  logic                              push;
  logic                              fifo_in_ready;
  logic                              fifo_out_valid;
  logic                              fifo_out_ready;
  logic [FIFO_W-1:0]                 fifo_out_data;
  logic                              pop;
  logic                              pop_frame;
  logic [CHANNELS-1:0][ROW_BITS-1:0] pop_row;
  logic [CHANNELS-1:0]               ser_msb;
  logic [CHANNELS-1:0]               pop_msb;

  // Rebuilds one parallel overhead byte from its row and column
  function automatic logic [7:0] rebuild(
    input logic [7:0]       rx,
    input logic [7:0]       h1,
    input logic [7:0]       h2,
    input logic [7:0]       es,
    input logic             aisp,
    input logic             ns,
    input logic             ais,
    input logic             tmode,
    input logic             kpass,
    input logic [ROW_W-1:0] row,
    input logic [COL_W-1:0] col
  );
    logic [7:0] b;
    b = ZERO_BYTE;
    if (row == FRAMING_ROW) begin
      if (col <= A1_LAST_COL) begin
        b = A1_VAL;
      end else if (col <= A2_LAST_COL) begin
        b = A2_VAL;
      end
    end else if (row == PTR_ROW) begin
      if (col <= A1_LAST_COL) begin
        b = aisp ? ONES_BYTE : {h1[7:SS_HI+1], rx[SS_HI:SS_LO], h1[SS_LO-1:0]};
      end else if (col <= A2_LAST_COL) begin
        b = aisp ? ONES_BYTE : h2;
      end else begin
        b = ns ? es : ZERO_BYTE;
      end
    end else if (row == APS_ROW && (col == K1_COL || col == K2_COL) && kpass) begin
      b = rx;
    end
    if (tmode && ais) begin
      b = ONES_BYTE;
    end
    return b;
  endfunction

  // Line alarm per channel, forced or raised on out-of-frame
  assign ais_l = ais_force | (oof & ais_on_oof_en);

  // Rising edge of the synchronised overhead clock
  assign oh_edge = q.ck_s2 & ~q.ck_prev;

  // Capture side handshake and hand-off at payload envelope start
  assign toh_in_ready = ~q.row_full;
  assign push         = q.row_full & spe_start & fifo_in_ready;

  // Serial side takes a new row only on an overhead edge while idle
  assign fifo_out_ready = oh_edge & ~q.busy;
  assign pop            = fifo_out_valid & fifo_out_ready;
  assign pop_frame      = fifo_out_data[FIFO_W-1];
  assign pop_row        = fifo_out_data[FIFO_W-2:0];

  // Next bit of each channel, most significant first
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      ser_msb[c] = q.ser[c][TOP];
      pop_msb[c] = pop_row[c][TOP];
    end
  end

  // Row buffer between capture and serial output
  rtosp_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_row_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({q.cap_frame, q.cap}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Next state: synchroniser, capture, serialiser and parallel rebuild
  always_comb begin
    d = q;
    d.ck_s1   = overhead_serial_clock;
    d.ck_s2   = q.ck_s1;
    d.ck_prev = q.ck_s2;

    // Shift bytes in until a full row is held
    if (toh_byte_valid && !q.row_full) begin
      for (int c = 0; c < CHANNELS; c++) begin
        d.cap[c] = {q.cap[c][ROW_BITS-BYTE_W-1:0], toh_byte[c]};
      end
      if (q.cap_cnt == '0) begin
        d.cap_frame = toh_first_of_frame;
      end
      if (q.cap_cnt == LAST_BYTE) begin
        d.cap_cnt  = '0;
        d.row_full = 1'b1;
      end else begin
        d.cap_cnt = q.cap_cnt + 1'b1;
      end
    end
    if (push) begin
      d.row_full = 1'b0;
    end

    // Serial output changes only on an overhead clock edge
    if (oh_edge) begin
      if (q.busy) begin
        for (int c = 0; c < CHANNELS; c++) begin
          d.sdata[c]   = ais_l[c] | ser_msb[c];
          d.par_acc[c] = q.par_acc[c] ^ ser_msb[c];
          d.ser[c]     = q.ser[c] << 1;
        end
        d.row_pulse = 1'b0;
        d.bit_cnt   = q.bit_cnt + 1'b1;
        d.busy      = (q.bit_cnt + 1'b1) != LAST_BIT;
      end else if (pop) begin
        for (int c = 0; c < CHANNELS; c++) begin
          if (pop_frame) begin
            d.sdata[c]   = ais_l[c] | q.par_acc[c];
            d.par_acc[c] = pop_msb[c];
          end else begin
            d.sdata[c]   = ais_l[c] | pop_msb[c];
            d.par_acc[c] = q.par_acc[c] ^ pop_msb[c];
          end
          d.ser[c] = pop_row[c] << 1;
        end
        d.bit_cnt   = '0;
        d.busy      = 1'b1;
        d.row_pulse = 1'b1;
        d.clk_en    = 1'b1;
      end else begin
        d.row_pulse = 1'b0;
        d.clk_en    = 1'b0;
      end
    end

    // Parallel overhead rebuild, or pass-through when the mover is bypassed
    d.par_v = par_in_valid;
    if (par_in_valid) begin
      for (int c = 0; c < CHANNELS; c++) begin
        d.pbus[c] = pm_bypass ? par_in_data[c] :
                    rebuild(par_in_data[c], ptr_h1[c], ptr_h2[c], es_byte[c], ptr_ais_p[c], neg_stuff[c],
                            ais_l[c], transport_mode, aps_pass, par_row_idx, par_col_idx);
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rx_overhead_row_pulse    = q.row_pulse;
  assign rx_overhead_clock_enable = q.clk_en;
  assign rx_overhead_serial_data  = q.sdata;
  assign par_out_valid            = q.par_v;
  assign par_out_data             = q.pbus;

  // Checks
  property p_push_at_spe;
    @(posedge clk) disable iff (!rst_b)
    push |-> spe_start ##1 !q.row_full;
  endproperty
  a_push_at_spe: assert property (p_push_at_spe) else $error("row moved outside envelope start");

  property p_capture_hold;
    @(posedge clk) disable iff (!rst_b)
    (q.row_full && !push) |=> $stable(q.cap) && q.row_full;
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("full row changed before hand-off");

  property p_launch_on_edge;
    @(posedge clk) disable iff (!rst_b)
    !oh_edge |=> $stable(rx_overhead_serial_data) && $stable(rx_overhead_clock_enable)
                 && $stable(rx_overhead_row_pulse);
  endproperty
  a_launch_on_edge: assert property (p_launch_on_edge) else $error("serial output moved off edge");

  property p_pulse_one_cycle;
    @(posedge clk) disable iff (!rst_b)
    (oh_edge && q.busy) |=> !rx_overhead_row_pulse && rx_overhead_clock_enable;
  endproperty
  a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("row pulse too wide");

  property p_pulse_with_enable;
    @(posedge clk) disable iff (!rst_b)
    rx_overhead_row_pulse |-> rx_overhead_clock_enable && q.bit_cnt == '0;
  endproperty
  a_pulse_with_enable: assert property (p_pulse_with_enable) else $error("row pulse without enable");

  property p_msb_first;
    @(posedge clk) disable iff (!rst_b)
    (oh_edge && q.busy) |=> rx_overhead_serial_data == ($past(ser_msb) | $past(ais_l));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("serial bit not next msb");

  property p_parity;
    @(posedge clk) disable iff (!rst_b)
    (pop && pop_frame) |=> rx_overhead_serial_data == ($past(q.par_acc) | $past(ais_l));
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_ais_ones;
    @(posedge clk) disable iff (!rst_b)
    (oh_edge && (q.busy || pop)) |=> (rx_overhead_serial_data & $past(ais_l)) == $past(ais_l);
  endproperty
  a_ais_ones: assert property (p_ais_ones) else $error("alarm bit not one");

  property p_row_len;
    @(posedge clk) disable iff (!rst_b)
    q.bit_cnt <= LAST_BIT && (q.busy || q.bit_cnt == '0 || q.bit_cnt == LAST_BIT);
  endproperty
  a_row_len: assert property (p_row_len) else $error("row bit count out of range");

  property p_zero_rows;
    @(posedge clk) disable iff (!rst_b)
    (par_in_valid && !pm_bypass && !(transport_mode && ais_l[0]) && (par_row_idx == 4'h1 || par_row_idx > APS_ROW))
      |=> par_out_data[0] == ZERO_BYTE;
  endproperty
  a_zero_rows: assert property (p_zero_rows) else $error("unused overhead not zero");

  property p_h3;
    @(posedge clk) disable iff (!rst_b)
    (par_in_valid && !pm_bypass && !transport_mode && par_row_idx == PTR_ROW && par_col_idx > A2_LAST_COL)
      |=> par_out_data[0] == ($past(neg_stuff[0]) ? $past(es_byte[0]) : ZERO_BYTE);
  endproperty
  a_h3: assert property (p_h3) else $error("stuff byte wrong");

  property p_aps;
    @(posedge clk) disable iff (!rst_b)
    (par_in_valid && !pm_bypass && !transport_mode && par_row_idx == APS_ROW && par_col_idx == K1_COL)
      |=> par_out_data[0] == ($past(aps_pass) ? $past(par_in_data[0]) : ZERO_BYTE);
  endproperty
  a_aps: assert property (p_aps) else $error("protection byte wrong");

  property p_cov_row;
    @(posedge clk) disable iff (!rst_b)
    $rose(rx_overhead_row_pulse);
  endproperty
  c_cov_row: cover property (p_cov_row);

  property p_cov_back_to_back;
    @(posedge clk) disable iff (!rst_b)
    (oh_edge && q.busy && q.bit_cnt == LAST_BIT - 1'b1) ##[1:200] pop;
  endproperty
  c_cov_back_to_back: cover property (p_cov_back_to_back);

  property p_cov_fifo_full;
    @(posedge clk) disable iff (!rst_b)
    q.row_full && !fifo_in_ready;
  endproperty
  c_cov_fifo_full: cover property (p_cov_fifo_full);

  property p_cov_ais_frame;
    @(posedge clk) disable iff (!rst_b)
    pop && pop_frame && (ais_l != '0);
  endproperty
  c_cov_ais_frame: cover property (p_cov_ais_frame);

endmodule

// >>> testbench/rtosp_fabric_model.sv
// Fabric side model: makes the overhead clock and collects serial rows
`timescale 1ns/100ps
module rtosp_fabric_model (
  output logic                          ohclk,
  input  wire logic                     row_pulse,
  input  wire logic                     clk_en,
  input  wire logic [rtosp_pkg::CHANNELS-1:0] sdata
);
  import rtosp_pkg::*;
  logic [ROW_BITS-1:0] shift_q [CHANNELS];
  logic [ROW_BITS-1:0] rows [4][CHANNELS];
  int                  n_bits;
  int                  n_rows;
  int                  n_bad;

  // Free-running overhead clock, phase unrelated to the system clock
  initial begin
    ohclk = 1'b0;
    n_bits = 0;
    n_rows = 0;
    n_bad = 0;
    #37;
    forever #80 ohclk = ~ohclk;
  end

  // Sample only on enable, restart the bit count at each row pulse
  always @(posedge ohclk) begin
    if (row_pulse === 1'b1 && clk_en !== 1'b1) begin
      n_bad++;
    end
    if (clk_en === 1'b1) begin
      if (row_pulse === 1'b1) begin
        if (n_bits != 0 && n_bits != ROW_BITS) n_bad++;
        n_bits = 0;
      end else if (n_bits == 0 || n_bits == ROW_BITS) begin
        n_bad++;
      end
      for (int c = 0; c < CHANNELS; c++) begin
        shift_q[c] = {shift_q[c][ROW_BITS-2:0], sdata[c]};
      end
      n_bits++;
      if (n_bits == ROW_BITS && n_rows < 4) begin
        rows[n_rows] = shift_q;
        n_rows++;
      end
    end
  end
endmodule

// >>> testbench/rx_overhead_serial_port_tb.sv
// Self-checking bench for the receive overhead serial port core
`timescale 1ns/100ps
module rx_overhead_serial_port_tb;
  import rtosp_pkg::*;
  logic                            clk, rst_b, overhead_serial_clock, toh_byte_valid, toh_first_of_frame;
  logic                            toh_in_ready, spe_start, rx_overhead_row_pulse, rx_overhead_clock_enable;
  logic                            par_in_valid, pm_bypass, transport_mode, aps_pass, par_out_valid;
  logic [CHANNELS-1:0]             ais_force, ais_on_oof_en, oof, rx_overhead_serial_data, ptr_ais_p, neg_stuff;
  logic [CHANNELS-1:0][BYTE_W-1:0] toh_byte, par_in_data, ptr_h1, ptr_h2, es_byte, par_out_data;
  logic [ROW_W-1:0]                par_row_idx;
  logic [COL_W-1:0]                par_col_idx;
  logic [7:0]                      sent [3][CHANNELS][ROW_BYTES];
  int                              n_mismatch, n_compared;
  int                              pr [13] = '{0, 0, 0, 0, 0, 3, 3, 3, 3, 4, 4, 4, 8};
  int                              pc [13] = '{0, 11, 12, 23, 24, 0, 12, 24, 35, 12, 24, 13, 35};

  rtosp_core dut (
    .clk, .rst_b, .overhead_serial_clock, .toh_byte_valid, .toh_first_of_frame, .toh_byte, .toh_in_ready,
    .spe_start, .ais_force, .ais_on_oof_en, .oof, .rx_overhead_row_pulse, .rx_overhead_clock_enable,
    .rx_overhead_serial_data, .par_in_valid, .par_row_idx, .par_col_idx, .par_in_data, .pm_bypass,
    .transport_mode, .aps_pass, .ptr_h1, .ptr_h2, .ptr_ais_p, .neg_stuff, .es_byte, .par_out_valid,
    .par_out_data
  );
  rtosp_fabric_model fab (
    .ohclk(overhead_serial_clock), .row_pulse(rx_overhead_row_pulse), .clk_en(rx_overhead_clock_enable),
    .sdata(rx_overhead_serial_data)
  );

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  // Comparisons for bytes and for flags
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded waits
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (toh_in_ready !== 1'b1 && i < 8);
    cmp_flag(toh_in_ready, 1'b1, "ready back");
    if (toh_in_ready !== 1'b1) test_done();
  endtask
  task automatic wait_rows(input int n);
    for (int i = 0; i < 40000 && fab.n_rows < n; i++) @(posedge clk);
    if (fab.n_rows < n) begin
      n_mismatch++;
      $display("MISMATCH %0t row not received", $time);
      test_done();
    end
  endtask

  // Capture one row, offer a refused byte, then hand it off
  task automatic load_row(input int r, input logic first);
    wait_ready();
    for (int j = 0; j < ROW_BYTES; j++) begin
      @(posedge clk);
      toh_byte_valid <= 1'b1;
      toh_first_of_frame <= first && j == 0;
      for (int c = 0; c < CHANNELS; c++) begin
        sent[r][c][j] = 8'(c * 37 + j * 11 + r * 59 + 3);
        toh_byte[c] <= sent[r][c][j];
      end
    end
    @(posedge clk);
    toh_byte <= '1;
    #1 cmp_flag(toh_in_ready, 1'b0, "ready after row");
    @(posedge clk);
    toh_byte_valid <= 1'b0;
    spe_start <= 1'b1;
    @(posedge clk);
    spe_start <= 1'b0;
  endtask

  // Compare a collected row with what was sent
  task automatic check_row(input int r, input logic first, input logic [7:0] par, input logic [7:0] alm);
    logic [7:0] e;
    for (int c = 0; c < CHANNELS; c++) begin
      for (int j = 0; j < ROW_BYTES; j++) begin
        e = sent[r][c][j];
        if (first && j == 0) e[7] = par[c];
        if (alm[c]) e = ONES_BYTE;
        cmp_byte(fab.rows[r][c][ROW_BITS-1-8*j -: 8], e, "serial byte");
      end
    end
  endtask

  // Expected rebuilt parallel byte
  function automatic logic [7:0] exp_par(input int r, input int k, input int c, input logic [7:0] d, input int m);
    logic [7:0] h1;
    h1 = 8'(8'h60 + c);
    if (m == 2) return d;
    if (m == 1 && c == 2) return ONES_BYTE;
    if (r == 0) return k < 12 ? A1_VAL : k < 24 ? A2_VAL : ZERO_BYTE;
    if (r == 3 && k < 24 && c == 1) return ONES_BYTE;
    if (r == 3 && k < 12) return {h1[7:4], d[3:2], h1[1:0]};
    if (r == 3 && k < 24) return 8'(8'h0A + 2 * c);
    if (r == 3) return c % 2 == 0 ? 8'(8'hE0 + c) : ZERO_BYTE;
    if (r == 4 && (k == 12 || k == 24) && m == 0) return d;
    return ZERO_BYTE;
  endfunction

  task automatic test_reset();
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    cmp_flag(rx_overhead_row_pulse, 1'b0, "pulse");
    cmp_flag(rx_overhead_clock_enable, 1'b0, "enable");
    cmp_byte(rx_overhead_serial_data, ZERO_BYTE, "sdata");
    cmp_flag(par_out_valid, 1'b0, "pvalid");
    cmp_flag(toh_in_ready, 1'b1, "ready");
    $display("test_reset done");
  endtask

  // Two frame-first rows back to back, then an alarmed row
  task automatic test_serial();
    logic [7:0] par_b;
    par_b = '0;
    load_row(0, 1'b1);
    load_row(1, 1'b1);
    wait_rows(2);
    @(posedge clk);
    ais_force <= 8'h04;
    ais_on_oof_en <= 8'h18;
    oof <= 8'h28;
    load_row(2, 1'b0);
    wait_rows(3);
    for (int c = 0; c < CHANNELS; c++) begin
      for (int j = 0; j < ROW_BYTES; j++) par_b[c] ^= ^sent[0][c][j];
    end
    check_row(0, 1'b1, 8'h00, 8'h00);
    check_row(1, 1'b1, par_b, 8'h00);
    check_row(2, 1'b0, 8'h00, 8'h0C);
    cmp_byte(8'(fab.n_bad), 8'h00, "framing faults");
    @(posedge clk);
    {ais_force, ais_on_oof_en, oof} <= '0;
    $display("test_serial done");
  endtask

  // Parallel rebuild over positions in three modes
  task automatic test_par();
    @(posedge clk);
    ais_force <= 8'h04;
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 13; p++) begin
        @(posedge clk);
        par_in_valid <= 1'b1;
        par_row_idx <= 4'(pr[p]);
        par_col_idx <= 6'(pc[p]);
        aps_pass <= m == 0;
        transport_mode <= m == 1;
        pm_bypass <= m == 2;
        for (int c = 0; c < CHANNELS; c++) par_in_data[c] <= 8'(8'h9C ^ (c * 17 + p));
        @(posedge clk);
        par_in_valid <= 1'b0;
        #1 cmp_flag(par_out_valid, 1'b1, "par valid");
        for (int c = 0; c < CHANNELS; c++) begin
          cmp_byte(par_out_data[c], exp_par(pr[p], pc[p], c, 8'(8'h9C ^ (c * 17 + p)), m), "par byte");
        end
      end
    end
    $display("test_par done");
  endtask

  // Time-zero values and test sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {toh_byte_valid, toh_first_of_frame, spe_start, par_in_valid, pm_bypass, transport_mode, aps_pass} = '0;
    {ais_force, ais_on_oof_en, oof, toh_byte, par_in_data, par_row_idx, par_col_idx} = '0;
    ptr_ais_p = 8'h02;
    neg_stuff = 8'h55;
    for (int c = 0; c < CHANNELS; c++) begin
      ptr_h1[c] = 8'(8'h60 + c);
      ptr_h2[c] = 8'(8'h0A + 2 * c);
      es_byte[c] = 8'(8'hE0 + c);
    end
    n_mismatch = 0;
    n_compared = 0;
    test_reset();
    test_serial();
    test_par();
    test_done();
  end
endmodule
